// ---- hw/pwm_cfg.svh ----
// Overview of operation
// - Unit runs only while module-on bit set.
// - Polarity select inverts active and idle levels.
// - Waveform clock is system clock /2,/4,/8,/16.
// - Counter overflow sets the overflow flag.
// - Pin share select hands pin to waveform.
// - Period lasts period value waveform clocks.
// - Zero period gives constant inactive level.
// - Duty value sets active part length.
// - Period not above duty gives constant active.
// - Zero duty gives constant inactive level.
// - Pin off still counts as 8-bit timer.
// - Interrupt forwarded only while irq enable set.
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PWM_ADDR_CONTROL 8'hd1
`define PWM_ADDR_PERIOD 8'hd2
`define PWM_ADDR_DUTY 8'hd3
`define PWM_ADDR_IRQ_STATUS 8'hd4
`define PWM_ADDR_IRQ_MASK 8'hd5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PWM_BIT_MODULE_ON 7
`define PWM_BIT_POLARITY 6
`define PWM_BIT_DIV_HI 5
`define PWM_BIT_DIV_LO 4
`define PWM_BIT_OVF_FLAG 1
`define PWM_BIT_PIN_SHARE 0
`define PWM_BIT_IRQ 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PWM_RST_CONTROL 8'h00
`define PWM_RST_PERIOD 8'h00
`define PWM_RST_DUTY 8'h00
`define PWM_RST_IRQ 1'b0

// ----------------------------------------------------------------
// Prescaler terminal counts, each one less than its divisor
// ----------------------------------------------------------------
`define PWM_LAST_DIV2 4'h1
`define PWM_LAST_DIV4 4'h3
`define PWM_LAST_DIV8 4'h7
`define PWM_LAST_DIV16 4'hf

`endif

// ---- hw/pwm_pkg.sv ----
package pwm_pkg;

  typedef logic [7:0] pwm_byte_t;

  typedef enum logic [1:0] {
    PWM_DIV2 = 2'h0,
    PWM_DIV4 = 2'h1,
    PWM_DIV8 = 2'h2,
    PWM_DIV16 = 2'h3
  } pwm_div_e;

endpackage

// ---- hw/pwm_prescale.sv ----
`timescale 1ns/10ps
`include "pwm_cfg.svh"
module pwm_prescale (
  input logic clk,
  input logic rst,
  input logic run,
  input pwm_pkg::pwm_div_e div_sel,
  output logic tick
);

  logic [3:0] div_cnt_r;
  logic [3:0] div_cnt_nxt;
  wire [3:0] last_cnt;

  // Last count value before the tick: divisor minus one.
  function automatic logic [3:0] last_of(input pwm_pkg::pwm_div_e sel);
    case (sel)
      pwm_pkg::PWM_DIV2: last_of = `PWM_LAST_DIV2;
      pwm_pkg::PWM_DIV4: last_of = `PWM_LAST_DIV4;
      pwm_pkg::PWM_DIV8: last_of = `PWM_LAST_DIV8;
      default: last_of = `PWM_LAST_DIV16;
    endcase
  endfunction

  assign last_cnt = last_of(div_sel);
  assign tick = run && (div_cnt_r == last_cnt);
  assign div_cnt_nxt = (!run || tick) ? 4'h0 : div_cnt_r + 4'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= 4'h0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

endmodule

// ---- hw/pwm_period_cnt.sv ----
`timescale 1ns/10ps
module pwm_period_cnt (
  input logic clk,
  input logic rst,
  input logic run,
  input logic tick,
  input pwm_pkg::pwm_byte_t period,
  output pwm_pkg::pwm_byte_t count,
  output logic ovf
);

  pwm_pkg::pwm_byte_t count_r;
  pwm_pkg::pwm_byte_t count_nxt;
  wire at_top;

  // A zero period leaves the counter free running over all 256 steps.
  function automatic logic is_top(input pwm_pkg::pwm_byte_t c, input pwm_pkg::pwm_byte_t p);
    if (p == 8'h00) begin
      is_top = (c == 8'hff);
    end else begin
      is_top = ({1'b0, c} + 9'h001 >= {1'b0, p});
    end
  endfunction

  assign at_top = is_top(count_r, period);
  assign ovf = run && tick && at_top;
  assign count_nxt = !run ? 8'h00 : !tick ? count_r : at_top ? 8'h00 : count_r + 8'h01;
  assign count = count_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// ---- hw/pwm_8bit_gen.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "pwm_cfg.svh"
module pwm_8bit_gen (
  input logic clk,
  input logic rst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic waveform_output_pin,
  output logic waveform_output_pin_oe,
  output logic pwm_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic module_on_bit_r;
  logic output_polarity_select_r;
  pwm_pkg::pwm_div_e clock_divider_select_r;
  logic period_overflow_flag_r;
  logic pin_share_select_r;
  pwm_pkg::pwm_byte_t period_value_r;
  pwm_pkg::pwm_byte_t duty_value_r;
  logic irq_status_r;
  logic waveform_irq_enable_r;
  logic [7:0] rdata_r;
  logic pin_out_r;
  logic pin_oe_r;

  logic period_overflow_flag_nxt;
  logic irq_status_nxt;
  logic [7:0] rdata_nxt;
  logic pin_out_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_control = (reg_addr == `PWM_ADDR_CONTROL);
  wire hit_period = (reg_addr == `PWM_ADDR_PERIOD);
  wire hit_duty = (reg_addr == `PWM_ADDR_DUTY);
  wire hit_status = (reg_addr == `PWM_ADDR_IRQ_STATUS);
  wire hit_mask = (reg_addr == `PWM_ADDR_IRQ_MASK);
  wire wr_control = reg_wr && hit_control;
  wire wr_period = reg_wr && hit_period;
  wire wr_duty = reg_wr && hit_duty;
  wire wr_status = reg_wr && hit_status;
  wire wr_mask = reg_wr && hit_mask;

  wire [7:0] control_view = {module_on_bit_r, output_polarity_select_r,
                             clock_divider_select_r, 2'h0,
                             period_overflow_flag_r, pin_share_select_r};

  wire [7:0] control_rst = `PWM_RST_CONTROL;

  // ----------------------------------------------------------------
  // Waveform engine
  // ----------------------------------------------------------------
  wire wave_tick;
  wire period_ovf;
  pwm_pkg::pwm_byte_t period_count;

  pwm_prescale u_prescale (
    .clk(clk),
    .rst(rst),
    .run(module_on_bit_r),
    .div_sel(clock_divider_select_r),
    .tick(wave_tick)
  );

  pwm_period_cnt u_period_cnt (
    .clk(clk),
    .rst(rst),
    .run(module_on_bit_r),
    .tick(wave_tick),
    .period(period_value_r),
    .count(period_count),
    .ovf(period_ovf)
  );

  // Active level holds while the count is below the duty value; the zero
  // period and zero duty cases force the idle level, and a period that does
  // not exceed the duty forces the active level.
  wire period_zero = (period_value_r == 8'h00);
  wire duty_zero = (duty_value_r == 8'h00);
  wire duty_full = (period_value_r <= duty_value_r);
  wire in_duty = (period_count < duty_value_r);
  wire wave_active = !period_zero && !duty_zero && (duty_full || in_duty);

  // With the module off the pin is released and the idle level is staged.
  assign pin_out_nxt = (module_on_bit_r && wave_active) ^ output_polarity_select_r;
  wire pin_oe_nxt = module_on_bit_r && pin_share_select_r;

  // ----------------------------------------------------------------
  // Flags and read data
  // ----------------------------------------------------------------
  // Writing zero clears the overflow flag, writing one keeps it; the status bit clears on writing one; overflow wins.
  assign period_overflow_flag_nxt = period_ovf ||
    (period_overflow_flag_r && !(wr_control && !reg_wdata[`PWM_BIT_OVF_FLAG]));
  assign irq_status_nxt = period_ovf ||
    (irq_status_r && !(wr_status && reg_wdata[`PWM_BIT_IRQ]));

  assign rdata_nxt = !reg_rd ? 8'h00 :
                     hit_control ? control_view :
                     hit_period ? period_value_r :
                     hit_duty ? duty_value_r :
                     hit_status ? {7'h00, irq_status_r} :
                     hit_mask ? {7'h00, waveform_irq_enable_r} :
                     8'h00;

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      module_on_bit_r <= control_rst[`PWM_BIT_MODULE_ON];
      output_polarity_select_r <= control_rst[`PWM_BIT_POLARITY];
      clock_divider_select_r <= pwm_pkg::pwm_div_e'(control_rst[`PWM_BIT_DIV_HI:`PWM_BIT_DIV_LO]);
      pin_share_select_r <= control_rst[`PWM_BIT_PIN_SHARE];
    end else if (wr_control) begin
      module_on_bit_r <= reg_wdata[`PWM_BIT_MODULE_ON];
      output_polarity_select_r <= reg_wdata[`PWM_BIT_POLARITY];
      clock_divider_select_r <= pwm_pkg::pwm_div_e'(reg_wdata[`PWM_BIT_DIV_HI:`PWM_BIT_DIV_LO]);
      pin_share_select_r <= reg_wdata[`PWM_BIT_PIN_SHARE];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_value_r <= `PWM_RST_PERIOD;
      duty_value_r <= `PWM_RST_DUTY;
    end else begin
      if (wr_period) begin
        period_value_r <= reg_wdata;
      end
      if (wr_duty) begin
        duty_value_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_overflow_flag_r <= `PWM_RST_IRQ;
      irq_status_r <= `PWM_RST_IRQ;
      waveform_irq_enable_r <= `PWM_RST_IRQ;
    end else begin
      period_overflow_flag_r <= period_overflow_flag_nxt;
      irq_status_r <= irq_status_nxt;
      if (wr_mask) begin
        waveform_irq_enable_r <= reg_wdata[`PWM_BIT_IRQ];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign waveform_output_pin = pin_out_r;
  assign waveform_output_pin_oe = pin_oe_r;
  assign pwm_irq = irq_status_r && waveform_irq_enable_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper: system cycles since the last waveform tick, restarted whenever
  // the control register is written so a divider change is not misjudged.
  logic [4:0] gap_r;
  logic gap_valid_r;
  always_ff @(posedge clk) begin
    if (rst || wr_control || !module_on_bit_r) begin
      gap_r <= 5'h00;
      gap_valid_r <= 1'b0;
    end else if (wave_tick) begin
      gap_r <= 5'h00;
      gap_valid_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 5'h01;
    end
  end

  wire [4:0] divisor = 5'h02 << clock_divider_select_r;

  property p_off_quiet;
    @(posedge clk) disable iff (rst)
    !module_on_bit_r |-> (!wave_tick && !period_ovf) ##1 (period_count == 8'h00);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("waveform unit active while module is off");

  property p_polarity_duty;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !period_zero && !duty_zero && in_duty
      |=> waveform_output_pin == !$past(output_polarity_select_r);
  endproperty
  a_polarity_duty: assert property (p_polarity_duty)
    else $error("pin not at active level during duty part");

  property p_polarity_rest;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !duty_full && !in_duty
      |=> waveform_output_pin == $past(output_polarity_select_r);
  endproperty
  a_polarity_rest: assert property (p_polarity_rest)
    else $error("pin not at idle level after duty part");

  property p_divider;
    @(posedge clk) disable iff (rst)
    wave_tick && gap_valid_r && !wr_control |-> gap_r + 5'h01 == divisor;
  endproperty
  a_divider: assert property (p_divider)
    else $error("waveform clock spacing does not match divider select");

  property p_flag_set;
    @(posedge clk) disable iff (rst)
    period_ovf |=> period_overflow_flag_r && irq_status_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow did not set the flag");

  property p_flag_hold;
    @(posedge clk) disable iff (rst)
    period_overflow_flag_r && !(wr_control && !reg_wdata[`PWM_BIT_OVF_FLAG])
      |=> period_overflow_flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag dropped without a clearing write");

  property p_flag_clear;
    @(posedge clk) disable iff (rst)
    wr_control && !reg_wdata[`PWM_BIT_OVF_FLAG] && !period_ovf |=> !period_overflow_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("writing zero did not clear the overflow flag");

  property p_pin_share;
    @(posedge clk) disable iff (rst)
    !pin_share_select_r |=> !waveform_output_pin_oe;
  endproperty
  a_pin_share: assert property (p_pin_share)
    else $error("pin driven while pin share select is zero");

  property p_period_len;
    @(posedge clk) disable iff (rst)
    period_ovf && !period_zero |-> period_count == period_value_r - 8'h01;
  endproperty
  a_period_len: assert property (p_period_len)
    else $error("overflow not at end of programmed period");

  property p_zero_period;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && period_zero |=> waveform_output_pin == $past(output_polarity_select_r);
  endproperty
  a_zero_period: assert property (p_zero_period)
    else $error("zero period did not give the idle level");

  property p_full_duty;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !period_zero && !duty_zero && duty_full
      |=> waveform_output_pin == !$past(output_polarity_select_r);
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("period not above duty did not hold the active level");

  property p_zero_duty;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && duty_zero |=> waveform_output_pin == $past(output_polarity_select_r);
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("zero duty did not give the idle level");

  property p_timer_mode;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !pin_share_select_r && period_ovf |=> irq_status_r ##0 !waveform_output_pin_oe;
  endproperty
  a_timer_mode: assert property (p_timer_mode)
    else $error("timer mode overflow not flagged");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
    (!waveform_irq_enable_r |-> !pwm_irq) and (irq_status_r && waveform_irq_enable_r |-> pwm_irq);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt output does not follow flag and enable");

  property p_wrap;
    @(posedge clk) disable iff (rst)
    period_ovf && !wr_control |=> period_count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to zero after overflow");

  property p_reset_regs;
    @(posedge clk)
    rst |=> control_view == 8'h00 && period_value_r == 8'h00 && duty_value_r == 8'h00;
  endproperty
  a_reset_regs: assert property (p_reset_regs)
    else $error("waveform registers not cleared by reset");

  property p_off_pin;
    @(posedge clk) disable iff (rst)
    !module_on_bit_r |=> waveform_output_pin == $past(output_polarity_select_r) &&
      !waveform_output_pin_oe;
  endproperty
  a_off_pin: assert property (p_off_pin)
    else $error("pin not idle and released while module is off");

  property p_pin_drive;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && pin_share_select_r |=> waveform_output_pin_oe;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("pin not driven while pin share select is one");

  property p_timer_count;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !pin_share_select_r && wave_tick && !period_ovf
      |=> period_count == $past(period_count) + 8'h01;
  endproperty
  a_timer_count: assert property (p_timer_count)
    else $error("timer mode counter did not advance on a waveform tick");

  property p_count_hold;
    @(posedge clk) disable iff (rst)
    module_on_bit_r && !wave_tick |=> period_count == $past(period_count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("period counter moved between waveform ticks");

  property p_reset_outputs;
    @(posedge clk)
    rst |=> !waveform_output_pin && !waveform_output_pin_oe && !pwm_irq &&
      reg_rdata == 8'h00;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not cleared by reset");

endmodule

// ---- test/pwm_8bit_gen_tb_top.sv ----
`timescale 1ns/10ps
module pwm_8bit_gen_tb_top;
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic pin;
  logic oe;
  logic irq;
  int failures;
  int checked;

  pwm_8bit_gen pwm_8bit_gen_i (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .waveform_output_pin(pin),
    .waveform_output_pin_oe(oe),
    .pwm_irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock, bus tasks and checks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task test_done;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Counts the cycles until the pin reaches the given level. The first look waits
  // for the updates of the clock edge that may just have passed.
  task wait_lvl(input logic lvl, output int n);
    n = 0;
    #1;
    while (pin !== lvl && n < 4000) begin
      step;
      n++;
    end
  endtask

  task wait_irq(output int n);
    n = 0;
    #1;
    while (irq !== 1'b1 && n < 1000) begin
      step;
      n++;
    end
  endtask

  // Kind 0 measures one toggling period, 1 expects constant active, 2 constant idle.
  task wave(input logic [7:0] ctl, input logic [7:0] per, input logic [7:0] duty,
            input int kind);
    logic act;
    int hi;
    int n;
    int div;
    act = ~ctl[6];
    div = 2 << ctl[5:4];
    wr(8'hd1, 8'h00);
    wr(8'hd2, per);
    wr(8'hd3, duty);
    wr(8'hd1, ctl);
    if (kind == 0) begin
      wait_lvl(~act, n);
      wait_lvl(act, n);
      wait_lvl(~act, hi);
      wait_lvl(act, n);
      check(hi[15:0], 16'(duty * div));
      check(16'(hi + n), 16'(per * div));
    end else begin
      n = 0;
      repeat (64) begin
        step;
        if (pin === (kind == 1 ? act : ~act)) begin
          n++;
        end
      end
      check(n[15:0], 16'd64);
    end
    check({15'h0, oe}, {15'h0, ctl[0]});
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    failures = 0;
    checked = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;

    rdchk(8'hd1, 8'h00);
    rdchk(8'hd2, 8'h00);
    rdchk(8'hd3, 8'h00);
    rdchk(8'hd4, 8'h00);
    rdchk(8'hd5, 8'h00);
    check({14'h0, pin, oe}, 16'h0000);
    $display("test reset done");

    wr(8'hd2, 8'ha5);
    wr(8'hd3, 8'h5a);
    wr(8'hd1, 8'h3d);
    wr(8'hd7, 8'hff);
    rdchk(8'hd2, 8'ha5);
    rdchk(8'hd3, 8'h5a);
    rdchk(8'hd1, 8'h31);
    rdchk(8'hd7, 8'h00);
    check({15'h0, oe}, 16'h0000);
    wr(8'hd1, 8'h40);
    step;
    check({14'h0, pin, oe}, 16'h0002);
    $display("test registers done");

    for (int c = 0; c < 4; c++) begin
      wave(8'h81 | 8'(c << 4), 8'h04, 8'h01, 0);
    end
    wave(8'hd1, 8'h05, 8'h03, 0);
    wave(8'h81, 8'hff, 8'hfe, 0);
    $display("test waveform done");

    for (int p = 0; p < 2; p++) begin
      wave(8'h81 | 8'(p << 6), 8'h00, 8'h03, 2);
      wave(8'h81 | 8'(p << 6), 8'h03, 8'h03, 1);
      wave(8'h81 | 8'(p << 6), 8'h02, 8'h09, 1);
      wave(8'h91 | 8'(p << 6), 8'h03, 8'h00, 2);
    end
    $display("test constant levels done");

    wr(8'hd1, 8'h00);
    wr(8'hd4, 8'h01);
    wr(8'hd5, 8'h01);
    wr(8'hd2, 8'h04);
    wr(8'hd3, 8'h01);
    wr(8'hd1, 8'h80);
    wait_irq(n);
    wr(8'hd4, 8'h01);
    wait_irq(n);
    check(16'(n + 2), 16'd8);
    check({15'h0, oe}, 16'h0000);
    rdchk(8'hd1, 8'h82);
    wr(8'hd5, 8'h00);
    step;
    check({15'h0, irq}, 16'h0000);
    rdchk(8'hd4, 8'h01);
    wr(8'hd5, 8'h01);
    step;
    check({15'h0, irq}, 16'h0001);
    wr(8'hd1, 8'h02);
    rdchk(8'hd1, 8'h02);
    wr(8'hd1, 8'h00);
    rdchk(8'hd1, 8'h00);
    wr(8'hd4, 8'h01);
    repeat (40) step;
    check({15'h0, irq}, 16'h0000);
    rdchk(8'hd4, 8'h00);
    $display("test timer and interrupt done");

    wr(8'hd1, 8'hc1);
    repeat (20) step;
    check({15'h0, irq}, 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'hd1, 8'h00);
    rdchk(8'hd2, 8'h00);
    rdchk(8'hd3, 8'h00);
    check({13'h0, pin, oe, irq}, 16'h0000);
    $display("test second reset done");
    test_done;
  end

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule
